/* pkg/ugi_pkg.sv */
// Constants shared by the global interrupt status and enable block
package ugi_pkg;

  // ----------------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------------
  localparam int          ADR_W          = 8;
  localparam int          DAT_W          = 32;
  localparam int          SEL_W          = 4;

  // ----------------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  OFF_STATUS     = 8'h04;
  localparam logic [7:0]  OFF_CLEAR      = 8'h08;
  localparam logic [7:0]  OFF_FORCE      = 8'h0C;
  localparam logic [7:0]  OFF_MASK       = 8'h10;
  localparam logic [7:0]  OFF_MASK_CLEAR = 8'h14;
  localparam logic [7:0]  OFF_MASK_SET   = 8'h18;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int          BIT_IDLE_BUS   = 0;
  localparam int          BIT_SOF        = 2;
  localparam int          BIT_RESET_END  = 3;
  localparam int          BIT_WAKEUP     = 4;
  localparam int          BIT_RESUME_END = 5;
  localparam int          BIT_HOST_RSM   = 6;
  localparam int          BIT_EP0        = 12;
  localparam int          EP_COUNT       = 7;

  // Writable global flags and implemented enable bits
  localparam logic [31:0] FLAG_BITS      = 32'h0000007D;
  localparam logic [31:0] MASK_BITS      = 32'h0007F07D;

  // ----------------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------------
  localparam logic [31:0] RST_FLAGS      = 32'h00000000;
  localparam logic [31:0] RST_MASK       = 32'h00000000;
  localparam logic [31:0] READ_ZERO      = 32'h00000000;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          IDLE_TIME_MS   = 3;
  localparam int          IDLE_TIME_NS   = IDLE_TIME_MS * 1000000;
  localparam int          IDLE_CYCLES    = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          IDLE_CNT_W     = 20;

endpackage

/* logic/ugi_global_irq.sv */
// Global interrupt status, force, clear and enable registers behind a classic Wishbone slave
//
// Notes on behaviour
// - The idle-bus flag rises once the bus has stayed in the idle J state for three frame periods.
// - The idle-bus flag clears on a one written to its clear bit or whenever the wakeup flag becomes set.
// - A raised idle-bus flag drives the interrupt only while its enable bit is one.
// - A one written to the clear register clears the matching global flag at bits 0 and 2 to 6.
// - A zero bit written to any write-only companion register leaves its target bit as it was.
// - A one written to the force register sets the matching global flag at the same positions.
// - The force register always reads as zero.
// - Each enable bit gates its source, one enables, and the enable register resets to zero.
// - A one written to the enable-clear register clears the matching enable bit.
// - A one written to the enable-set register sets the matching enable bit; the enable register is read-only.
// - Endpoint enable bits start at bit 12 for endpoint zero and only endpoints zero to six exist.
// - The wakeup flag clears on a one written to its clear bit or when the idle-bus flag becomes set.
// - The frame-start flag sets each time a start-of-frame token is detected.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/10ps

module ugi_global_irq #(
  parameter int IDLE_CYCLES = ugi_pkg::IDLE_CYCLES
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [ugi_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [ugi_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic [ugi_pkg::DAT_W-1:0]   wb_dat_i,
  output logic      [ugi_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        bus_idle_j_i,
  input  wire logic                        sof_detect_i,
  input  wire logic                        reset_end_i,
  input  wire logic                        wakeup_i,
  input  wire logic                        resume_end_i,
  input  wire logic                        host_resume_sent_i,
  input  wire logic [ugi_pkg::EP_COUNT-1:0] endpoint_irq_i,
  output logic                             irq_o
);

  typedef enum logic [1:0] {
    ST_WATCH  = 2'b01,
    ST_ASLEEP = 2'b10
  } ugi_state_type;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  ugi_state_type                     state_reg;
  ugi_state_type                     state_next;
  logic [ugi_pkg::IDLE_CNT_W-1:0]    cnt_reg;
  logic [ugi_pkg::IDLE_CNT_W-1:0]    cnt_next;
  logic                              det_set;
  logic [31:0]                       flags_reg;
  logic [31:0]                       flags_next;
  logic [31:0]                       mask_reg;
  logic [31:0]                       mask_next;
  logic                              irq_reg;
  logic                              irq_next;
  logic                              ack_reg;
  logic                              ack_next;
  logic [31:0]                       dat_reg;
  logic [31:0]                       dat_next;
  logic [31:0]                       sel_bits;
  logic [31:0]                       wr_data;
  logic                              req;
  logic                              wr_clr;
  logic                              wr_force;
  logic                              wr_mclr;
  logic                              wr_mset;
  logic [31:0]                       set_vec;
  logic [31:0]                       clr_vec;
  logic [31:0]                       ep_vec;
  logic [31:0]                       status_now;
  logic [31:0]                       status_next;
  logic [31:0]                       rdata;

  // ----------------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------------
  // One request per ack; the gap after ack keeps a held strobe from acting twice
  always_comb begin
    sel_bits = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wr_data  = wb_dat_i & sel_bits;
    req      = wb_cyc_i & wb_stb_i & ~ack_reg;
    wr_clr   = req & wb_we_i & (wb_adr_i == ugi_pkg::OFF_CLEAR);
    wr_force = req & wb_we_i & (wb_adr_i == ugi_pkg::OFF_FORCE);
    wr_mclr  = req & wb_we_i & (wb_adr_i == ugi_pkg::OFF_MASK_CLEAR);
    wr_mset  = req & wb_we_i & (wb_adr_i == ugi_pkg::OFF_MASK_SET);
  end

  // ----------------------------------------------------------------------------
  // Idle-bus detector
  // ----------------------------------------------------------------------------
  // Flag raised once per idle stretch; the bus must go active before it can fire again
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    det_set    = 1'b0;
    case (state_reg)
      ST_WATCH: begin
        if (!bus_idle_j_i) begin
          cnt_next = '0;
        end else if (cnt_reg == ugi_pkg::IDLE_CNT_W'(IDLE_CYCLES - 1)) begin
          det_set    = 1'b1;
          state_next = ST_ASLEEP;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + {{(ugi_pkg::IDLE_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_ASLEEP: begin
        if (!bus_idle_j_i) begin
          state_next = ST_WATCH;
        end
      end
      default: begin
        state_next = ST_WATCH;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_WATCH;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Global flags and enables
  // ----------------------------------------------------------------------------
  // Sets win over clears, so an event landing with a software clear survives
  always_comb begin
    set_vec = 32'h00000000;
    set_vec[ugi_pkg::BIT_IDLE_BUS]   = det_set;
    set_vec[ugi_pkg::BIT_SOF]        = sof_detect_i;
    set_vec[ugi_pkg::BIT_RESET_END]  = reset_end_i;
    set_vec[ugi_pkg::BIT_WAKEUP]     = wakeup_i;
    set_vec[ugi_pkg::BIT_RESUME_END] = resume_end_i;
    set_vec[ugi_pkg::BIT_HOST_RSM]   = host_resume_sent_i;
    if (wr_force) begin
      set_vec = set_vec | (wr_data & ugi_pkg::FLAG_BITS);
    end
    clr_vec = wr_clr ? (wr_data & ugi_pkg::FLAG_BITS) : 32'h00000000;
    clr_vec[ugi_pkg::BIT_IDLE_BUS] = clr_vec[ugi_pkg::BIT_IDLE_BUS] | set_vec[ugi_pkg::BIT_WAKEUP];
    clr_vec[ugi_pkg::BIT_WAKEUP]   = clr_vec[ugi_pkg::BIT_WAKEUP] | set_vec[ugi_pkg::BIT_IDLE_BUS];
    flags_next = ((flags_reg & ~clr_vec) | set_vec) & ugi_pkg::FLAG_BITS;
    mask_next  = mask_reg;
    if (wr_mclr) begin
      mask_next = mask_reg & ~wr_data;
    end else if (wr_mset) begin
      mask_next = mask_reg | wr_data;
    end
    mask_next = mask_next & ugi_pkg::MASK_BITS;
    ep_vec = 32'h00000000;
    ep_vec[ugi_pkg::BIT_EP0 +: ugi_pkg::EP_COUNT] = endpoint_irq_i;
    status_now  = flags_reg | ep_vec;
    status_next = flags_next | ep_vec;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flags_reg <= ugi_pkg::RST_FLAGS;
      mask_reg  <= ugi_pkg::RST_MASK;
      irq_reg   <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      mask_reg  <= mask_next;
      irq_reg   <= irq_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------------
  // Write-only and unmapped offsets read as zero; every access is acked
  always_comb begin
    if (wb_adr_i == ugi_pkg::OFF_STATUS) begin
      rdata = status_now;
    end else if (wb_adr_i == ugi_pkg::OFF_MASK) begin
      rdata = mask_reg;
    end else begin
      rdata = ugi_pkg::READ_ZERO;
    end
    ack_next = req;
    dat_next = (req && !wb_we_i) ? rdata : ugi_pkg::READ_ZERO;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= ugi_pkg::READ_ZERO;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // Ports come straight from the answer and interrupt flops, so no decode glitch reaches the pins
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o    = irq_reg;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Quiet cycle: no hardware source fires
  logic ev_quiet;
  assign ev_quiet = ~(det_set | sof_detect_i | reset_end_i | wakeup_i | resume_end_i | host_resume_sent_i);

  sequence s_read_force;
    req && !wb_we_i && wb_adr_i == ugi_pkg::OFF_FORCE;
  endsequence

  sequence s_read_status;
    req && !wb_we_i && wb_adr_i == ugi_pkg::OFF_STATUS;
  endsequence

  sequence s_read_mask;
    req && !wb_we_i && wb_adr_i == ugi_pkg::OFF_MASK;
  endsequence

  a_idle_flag_rise: assert property (state_reg == ST_WATCH && bus_idle_j_i && !wakeup_i && !wr_force &&
      cnt_reg == ugi_pkg::IDLE_CNT_W'(IDLE_CYCLES - 1) |=> flags_reg[ugi_pkg::BIT_IDLE_BUS])
    else $error("idle flag not raised after idle time");
  a_idle_no_early: assert property ($rose(flags_reg[ugi_pkg::BIT_IDLE_BUS]) && !$past(wr_force) |->
      $past(state_reg) == ST_WATCH && $past(cnt_reg) == ugi_pkg::IDLE_CNT_W'(IDLE_CYCLES - 1))
    else $error("idle flag raised early");
  a_wake_clr_idle: assert property (wakeup_i && !det_set && !wr_force |=> !flags_reg[ugi_pkg::BIT_IDLE_BUS])
    else $error("wakeup did not clear idle flag");
  a_idle_clr_wake: assert property (det_set && !wakeup_i && !wr_force |=> !flags_reg[ugi_pkg::BIT_WAKEUP])
    else $error("idle flag did not clear wakeup");
  a_irq_idle_gate: assert property (flags_reg[ugi_pkg::BIT_IDLE_BUS] && mask_reg[ugi_pkg::BIT_IDLE_BUS] |-> irq_o)
    else $error("enabled idle flag gives no interrupt");
  a_clear_write: assert property (wr_clr && ev_quiet |=> (flags_reg & $past(wr_data)) == 32'h00000000)
    else $error("clear write left a flag set");
  a_zero_keeps: assert property (wr_clr && ev_quiet |=>
      ((($past(flags_reg) & ~$past(wr_data)) ^ flags_reg) & ugi_pkg::FLAG_BITS) == 32'h00000000)
    else $error("zero bit of clear write changed a flag");
  a_force_write: assert property (wr_force |=>
      (flags_reg & $past(wr_data) & ugi_pkg::FLAG_BITS) == ($past(wr_data) & ugi_pkg::FLAG_BITS))
    else $error("force write did not set flags");
  a_force_reads0: assert property (s_read_force |=> wb_ack_o && wb_dat_o == 32'h00000000)
    else $error("force register read not zero");
  a_mask_reset: assert property ($past(rst_i) |-> mask_reg == 32'h00000000)
    else $error("enable register not zero after reset");
  a_mask_clear: assert property (wr_mclr |=> (mask_reg & $past(wr_data)) == 32'h00000000)
    else $error("enable clear failed");
  a_mask_set: assert property (wr_mset |=>
      (mask_reg & $past(wr_data)) == ($past(wr_data) & ugi_pkg::MASK_BITS))
    else $error("enable set failed");
  a_mask_unused: assert property ((mask_reg & ~ugi_pkg::MASK_BITS) == 32'h00000000)
    else $error("unimplemented enable bit set");
  a_sof_sets: assert property (sof_detect_i |=> flags_reg[ugi_pkg::BIT_SOF])
    else $error("frame start did not set flag");
  a_irq_or: assert property (irq_o == |((flags_reg | ep_vec) & mask_reg) || $changed(endpoint_irq_i))
    else $error("interrupt output not OR of gated sources");

  // Enable bits outside a companion write keep their value
  a_mclr_keeps: assert property (wr_mclr |=>
      (mask_reg & ~$past(wr_data)) == ($past(mask_reg) & ~$past(wr_data)))
    else $error("enable clear changed an unwritten bit");
  a_mset_keeps: assert property (wr_mset |=>
      (mask_reg & ~$past(wr_data)) == ($past(mask_reg) & ~$past(wr_data)))
    else $error("enable set changed an unwritten bit");

  // The enable register moves only through its set and clear companions
  a_mask_read_only: assert property (!wr_mclr && !wr_mset |=> mask_reg == $past(mask_reg))
    else $error("enable register changed without a companion write");

  // Flags stay put when no source fires and software writes nothing
  a_flags_hold: assert property (ev_quiet && !wr_clr && !wr_force |=> flags_reg == $past(flags_reg))
    else $error("flag changed with no event or write");

  // Any traffic restarts the idle count, so short stretches never add up
  a_idle_rearm: assert property (!bus_idle_j_i |=> cnt_reg == '0)
    else $error("idle count not restarted by traffic");

  // All enables off keeps the line low whatever the flags show
  a_irq_masked: assert property (mask_reg == 32'h00000000 |-> !irq_o)
    else $error("interrupt raised with every enable off");

  // Status reads mirror the endpoint inputs live, since nothing latches them here
  a_ep_status_live: assert property (s_read_status |=>
      wb_dat_o[ugi_pkg::BIT_EP0 +: ugi_pkg::EP_COUNT] == $past(endpoint_irq_i))
    else $error("endpoint bits not shown in status");

  // Status reads show the global flags as they stood when the request was taken
  a_status_flags: assert property (s_read_status |=>
      (wb_dat_o & ugi_pkg::FLAG_BITS) == $past(flags_reg))
    else $error("global flags not shown in status");

  // Enable reads return the enable register itself
  a_mask_read: assert property (s_read_mask |=> wb_dat_o == $past(mask_reg))
    else $error("enable register read mismatch");

endmodule

/* tb/ugi_bus_model.sv */
// Bus-side event source standing in for the host and the line monitor
`timescale 1ns/10ps

module ugi_bus_model (
  input  wire logic       ref_clk_i,
  output logic            bus_idle_j_o,
  output logic [4:0]      event_o
);
  // --------------------------------------------------------------------------
  // Line state
  // --------------------------------------------------------------------------
  // Start with traffic on the lines and no events pending
  initial begin
    bus_idle_j_o = 1'b0;
    event_o      = 5'h00;
  end

  // One-cycle event: 0 frame start, 1 reset end, 2 wakeup, 3 resume end, 4 upstream resume
  task automatic pulse(input int idx);
    @(posedge ref_clk_i);
    event_o <= 5'h01 << idx;
    @(posedge ref_clk_i);
    event_o <= 5'h00;
  endtask

  // Idle J for n sampling edges; traffic returns after so the detector rearms
  task automatic idle(input int n);
    @(posedge ref_clk_i);
    bus_idle_j_o <= 1'b1;
    repeat (n) @(posedge ref_clk_i);
    bus_idle_j_o <= 1'b0;
  endtask
endmodule

/* tb/test_usb_device_global_irq_regs.sv */
// Self-checking bench for the global interrupt status and enable block
`timescale 1ns/10ps

module test_usb_device_global_irq_regs;
  localparam int IDLE_N = 20;

  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        wb_cyc_i  = 1'b0;
  logic        wb_stb_i  = 1'b0;
  logic        wb_we_i   = 1'b0;
  logic [7:0]  wb_adr_i  = 8'h00;
  logic [3:0]  wb_sel_i  = 4'h0;
  logic [31:0] wb_dat_i  = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        bus_idle_j;
  logic [4:0]  events;
  logic [6:0]  ep_irq    = 7'h00;
  logic        irq_o;
  logic [31:0] rd;
  int          err_count = 0;
  int          cmp_count = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  ugi_bus_model far (.ref_clk_i(ref_clk_i), .bus_idle_j_o(bus_idle_j), .event_o(events));

  ugi_global_irq #(.IDLE_CYCLES(IDLE_N)) uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_idle_j_i(bus_idle_j),
    .sof_detect_i(events[0]), .reset_end_i(events[1]), .wakeup_i(events[2]),
    .resume_end_i(events[3]), .host_resume_sent_i(events[4]), .endpoint_irq_i(ep_irq),
    .irq_o(irq_o));

  // --------------------------------------------------------------------------
  // Closing and checking
  // --------------------------------------------------------------------------
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  // Interrupt line is looked at two edges on, after any registered update lands
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge ref_clk_i);
    cmp_count++;
    if (irq_o !== exp) begin
      err_count++;
      $display("Error %0t irq got %b expected %b", $time, irq_o, exp);
    end
  endtask

  // --------------------------------------------------------------------------
  // Classic Wishbone master: hold until ack is sampled, release right after
  // --------------------------------------------------------------------------
  // Waits for ack however long it takes; only the hang guard ends a wait
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge ref_clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat, 4'hF);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h00000000, 4'hF);
    chk_word(rd, exp);
  endtask

  // Hang guard, well above the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    wrap_up();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    logic [31:0] exp;
    int b [6] = '{0, 2, 3, 4, 5, 6};
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h10, 32'h00000000);
    wr(8'h0C, 32'h0000007D);
    rd_chk(8'h04, 32'h0000007D);
    rd_chk(8'h0C, 32'h00000000);
    exp = 32'h0000007D;
    // Clear flags one at a time; zeros elsewhere must leave the rest standing
    for (int i = 0; i < 6; i++) begin
      wr(8'h08, 32'h00000001 << b[i]);
      exp &= ~(32'h00000001 << b[i]);
      rd_chk(8'h04, exp);
    end
    // Disabled byte lanes write as zeros, so a force with lane 0 off sets nothing
    wb_xfer(1'b1, 8'h0C, 32'h0000007D, 4'hE);
    rd_chk(8'h04, 32'h00000000);
    wr(8'h18, 32'hFFFFFFFF);
    rd_chk(8'h10, 32'h0007F07D);
    wr(8'h10, 32'h00000000);
    rd_chk(8'h10, 32'h0007F07D);
    wr(8'h14, 32'h00000001);
    rd_chk(8'h10, 32'h0007F07C);
    rd_chk(8'h40, 32'h00000000);
    // Masked idle flag stays off the line until its enable returns
    wr(8'h0C, 32'h00000001);
    chk_irq(1'b0);
    wr(8'h18, 32'h00000001);
    chk_irq(1'b1);
    wr(8'h08, 32'h00000001);
    chk_irq(1'b0);
    // Every bus event source in turn, enabled, then acknowledged
    for (int i = 0; i < 5; i++) begin
      far.pulse(i);
      rd_chk(8'h04, 32'h00000004 << i);
      chk_irq(1'b1);
      wr(8'h08, 32'h00000004 << i);
      chk_irq(1'b0);
    end
    ep_irq <= 7'h40;
    rd_chk(8'h04, 32'h00040000);
    chk_irq(1'b1);
    wr(8'h14, 32'h00040000);
    chk_irq(1'b0);
    ep_irq <= 7'h00;
    // Idle stretch one edge short of the limit, then exactly the limit over a pending wakeup
    far.idle(IDLE_N - 1);
    rd_chk(8'h04, 32'h00000000);
    wr(8'h0C, 32'h00000010);
    far.idle(IDLE_N);
    rd_chk(8'h04, 32'h00000001);
    far.pulse(2);
    rd_chk(8'h04, 32'h00000010);
    wrap_up();
  end
endmodule
